// ### rtl/dcrzf_top.sv
// control bank of the eight-channel converter: de-emphasis, phase, read index,
// oversampling and shared-pin control, plus the zero-flag outputs
// assumes: a serial front end delivers each 16-bit control word as one
// ctl_word_valid pulse and shifts out rd_word, pulsing rd_word_take when done
`timescale 1ns/1ps
`include "dcrzf_regs.svh"

// What this block does
// R01 - phase bit inverts analog output when set
// R02 - rate field picks 44.1, 48, 32 kHz
// R03 - any of three enable bits enables de-emphasis
// R04 - increment bit enables auto-increment reads
// R05 - read index selects single-read register, reset 01h
// R06 - in auto-increment, read index marks last
// R07 - word top bit: 0 writes, 1 reads
// R08 - oversampling bit picks ratio by clock rate
// R09 - host should set oversampling at 192 kHz
// R10 - enable bit swaps shared pins to outputs
// R11 - output bits drive shared pins when enabled
// R12 - zero detect after 1024 zero periods
// R13 - each channel flags its zero detect
// R14 - combined flag is AND of eight
// R15 - polarity bit inverts flag active level
// R16 - polarity 0 high, polarity 1 low
// R17 - nonzero sample clears run and flag
module dcrzf_top (
    // clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // control words from the serial port
    input wire logic ctl_word_valid,
    input wire logic [15:0] ctl_word,
    // read words back to the serial port
    input wire logic rd_word_take,
    output logic rd_word_valid,
    output logic [15:0] rd_word,
    output logic rd_word_last,
    // system clock ratio strap: 1 for 128 or 192 times the sample rate
    input wire logic sys_clk_low_ratio,
    // audio side
    input wire logic word_clk_pin,
    input wire logic [7:0] chan_data_zero,
    // controls to the converter datapath
    output logic output_phase_invert,
    output logic deemph_enable,
    output dcrzf_pkg::dcrzf_de_rate_t deemph_rate_sel,
    output dcrzf_pkg::dcrzf_osr_t oversample_ratio,
    // shared and flag pins
    output logic [5:0] shared_pin,
    output logic [1:0] chan_zero_flag,
    output logic all_zero_flag
);
    // stored register bits
    // bit 7 of the de-emphasis word is not stored and reads back as 0
    logic [6:0] deemph_phase_flag_ctrl; // phase, polarity, rate and enables
    logic [7:0] read_index_ctrl; // increment bit and read index
    logic [7:0] oversample_gpout_ctrl; // ratio bit, gp enable and gp bits

    // read sequencer
    dcrzf_pkg::dcrzf_rd_state_t rd_state;
    logic [6:0] rd_cur; // index of word now offered

    // request decode
    wire req_read = ctl_word[`DCRZF_RW_BIT];
    wire wr_req = ctl_word_valid && !req_read; // R07
    wire rd_req = ctl_word_valid && req_read; // R07
    wire [6:0] req_idx = ctl_word[`DCRZF_IDX_HI:`DCRZF_IDX_LO];
    wire [7:0] req_data = ctl_word[`DCRZF_DATA_HI:0];
    wire wr_deemph = wr_req && (req_idx == `DCRZF_IDX_DEEMPH);
    wire wr_rdidx = wr_req && (req_idx == `DCRZF_IDX_RDIDX);
    wire wr_osgp = wr_req && (req_idx == `DCRZF_IDX_OSGP);

    // field views
    wire zero_flag_polarity = deemph_phase_flag_ctrl[`DCRZF_F_ZERO_POL];
    wire [1:0] rate_field = deemph_phase_flag_ctrl[`DCRZF_F_RATE_HI:`DCRZF_F_RATE_LO];
    wire [2:0] deen_bits = deemph_phase_flag_ctrl[`DCRZF_F_DEEN_HI:`DCRZF_F_DEEN_LO];
    wire read_auto_inc = read_index_ctrl[`DCRZF_F_INC];
    wire [6:0] read_index = read_index_ctrl[`DCRZF_F_RDIDX_HI:0];
    wire over_sel = oversample_gpout_ctrl[`DCRZF_F_OVER];
    wire gp_out_enable = oversample_gpout_ctrl[`DCRZF_F_GP_EN];
    wire [5:0] gp_out_bit = oversample_gpout_ctrl[`DCRZF_F_GPO_HI:0];

    // reserved rate code falls back to 44.1 kHz instead of an undefined curve
    wire [1:0] next_rate = (rate_field == 2'h3) ? 2'h0 : rate_field; // R02
    // ratio table: low system clock ratios halve the choice
    // the strap is a level on this clock; a change shows one edge later
    wire [1:0] next_osr = sys_clk_low_ratio ? (over_sel ? 2'h1 : 2'h0)
                                            : (over_sel ? 2'h2 : 2'h1); // R08

    // read word of a register: top bit 0, own index, data in the low byte
    function automatic logic [15:0] reg_word(input logic [6:0] idx, input logic [6:0] de,
                                             input logic [7:0] ri, input logic [7:0] og);
        logic [7:0] data;
        data = 8'h00;
        case (idx)
            `DCRZF_IDX_DEEMPH: data = {1'b0, de};
            `DCRZF_IDX_RDIDX: data = ri;
            `DCRZF_IDX_OSGP: data = og;
            default: data = 8'h00; // indices outside this bank read as zero data
        endcase
        return {1'b0, idx, data};
    endfunction

    // next index during auto-increment; wraps in seven bits
    wire [6:0] rd_step = 7'(rd_cur + 7'h01);
    // single reads ignore the index carried in the read word
    // first index of a new read
    wire [6:0] rd_first = read_auto_inc ? req_idx : read_index; // R04 R05

    // register writes; reads never disturb stored bits
    always_ff @(posedge core_clk) begin
        if (srst) begin
            deemph_phase_flag_ctrl <= `DCRZF_RST_DEEMPH;
            read_index_ctrl <= `DCRZF_RST_RDIDX; // R05
            oversample_gpout_ctrl <= `DCRZF_RST_OSGP;
        end else begin
            if (wr_deemph) begin
                deemph_phase_flag_ctrl <= req_data[6:0]; // R07
            end
            if (wr_rdidx) begin
                read_index_ctrl <= req_data; // R07
            end
            if (wr_osgp) begin
                oversample_gpout_ctrl <= req_data; // R07
            end
        end
    end

    // datapath controls, registered so they change together
    always_ff @(posedge core_clk) begin
        if (srst) begin
            output_phase_invert <= 1'b0;
            deemph_enable <= 1'b0;
            deemph_rate_sel <= dcrzf_pkg::dcrzf_de_44k1;
            oversample_ratio <= dcrzf_pkg::dcrzf_osr_64;
        end else begin
            output_phase_invert <= deemph_phase_flag_ctrl[`DCRZF_F_PHASE]; // R01
            deemph_enable <= |deen_bits; // R03
            deemph_rate_sel <= dcrzf_pkg::dcrzf_de_rate_t'(next_rate); // R02
            oversample_ratio <= dcrzf_pkg::dcrzf_osr_t'(next_osr); // R08
        end
    end

    // read sequencer: a new read request restarts it at once
    always_ff @(posedge core_clk) begin
        if (srst) begin
            rd_state <= dcrzf_pkg::dcrzf_rd_idle;
            rd_cur <= 7'h00;
            rd_word <= 16'h0000;
            rd_word_last <= 1'b0;
        end else if (rd_req) begin
            rd_state <= dcrzf_pkg::dcrzf_rd_send;
            rd_cur <= rd_first; // R05
            rd_word <= reg_word(rd_first, deemph_phase_flag_ctrl, read_index_ctrl,
                                oversample_gpout_ctrl);
            // single read is always last; auto read ends at the read index
            rd_word_last <= !read_auto_inc || (rd_first >= read_index); // R04 R06
        end else begin
            case (rd_state)
                dcrzf_pkg::dcrzf_rd_idle: begin
                    rd_word_last <= 1'b0;
                end
                dcrzf_pkg::dcrzf_rd_send: begin
                    if (rd_word_take && rd_word_last) begin
                        rd_state <= dcrzf_pkg::dcrzf_rd_idle; // R06
                        rd_word_last <= 1'b0;
                    end else if (rd_word_take) begin
                        rd_cur <= rd_step; // R06
                        rd_word <= reg_word(rd_step, deemph_phase_flag_ctrl, read_index_ctrl,
                                            oversample_gpout_ctrl);
                        rd_word_last <= (rd_step >= read_index); // R06
                    end
                end
                default: begin
                    rd_state <= dcrzf_pkg::dcrzf_rd_idle;
                end
            endcase
        end
    end

    // handshake output decoded from state
    assign rd_word_valid = (rd_state == dcrzf_pkg::dcrzf_rd_send);

    // zero detection and pin sharing
    dcrzf_flag_if flag_bus ();

    dcrzf_zero_det u_zero_det (
        .core_clk(core_clk),
        .srst(srst),
        .word_clk_pin(word_clk_pin),
        .chan_data_zero(chan_data_zero),
        .flags(flag_bus)
    );

    dcrzf_pin_mux u_pin_mux (
        .core_clk(core_clk),
        .srst(srst),
        .flags(flag_bus),
        .zero_flag_polarity(zero_flag_polarity),
        .gp_out_enable(gp_out_enable),
        .gp_out_bit(gp_out_bit),
        .shared_pin(shared_pin),
        .chan_zero_flag(chan_zero_flag),
        .all_zero_flag(all_zero_flag)
    );

    // checks next to the logic
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    sequence s_wr_deemph;
        wr_deemph ##1 !wr_deemph;
    endsequence

    sequence s_wr_osgp;
        wr_osgp ##1 !wr_osgp;
    endsequence

    // stored phase bit reaches the datapath two edges after the word
    property p_phase;
        s_wr_deemph |=> output_phase_invert == $past(ctl_word[`DCRZF_F_PHASE], 2);
    endproperty
    a_phase: assert property (p_phase) else $error("phase select not applied"); // R01

    // reserved rate code shows as 44.1 kHz
    property p_rate;
        s_wr_deemph |=> deemph_rate_sel ==
            (($past(ctl_word[4:3], 2) == 2'h3) ? 2'h0 : $past(ctl_word[4:3], 2));
    endproperty
    a_rate: assert property (p_rate) else $error("de-emphasis rate wrong"); // R02

    // any one enable bit is enough
    property p_deen;
        s_wr_deemph |=> deemph_enable == ($past(ctl_word[2:0], 2) != 3'h0);
    endproperty
    a_deen: assert property (p_deen) else $error("de-emphasis enable not ORed"); // R03

    // single read returns the register named by the read index
    property p_single;
        rd_req && !read_auto_inc |=> rd_word_valid && rd_word_last
            && rd_word[14:8] == $past(read_index);
    endproperty
    a_single: assert property (p_single) else $error("single read wrong index"); // R05

    // each take moves an auto read one index on
    property p_auto_step;
        rd_word_valid && rd_word_take && !rd_word_last && !rd_req |=>
            rd_word_valid && rd_word[14:8] == 7'($past(rd_word[14:8]) + 7'h01);
    endproperty
    a_auto_step: assert property (p_auto_step) else $error("auto read did not step"); // R04

    // the take of the last word ends the read
    property p_auto_end;
        rd_word_valid && rd_word_take && rd_word_last && !rd_req |=> !rd_word_valid;
    endproperty
    a_auto_end: assert property (p_auto_end) else $error("read ran past last index"); // R06

    // a read request never touches the store
    property p_read_keeps;
        rd_req |=> $stable(deemph_phase_flag_ctrl) && $stable(read_index_ctrl)
            && $stable(oversample_gpout_ctrl);
    endproperty
    a_read_keeps: assert property (p_read_keeps) else $error("read request wrote"); // R07

    // strap must hold across the check, else the table row is ambiguous
    property p_osr;
        s_wr_osgp ##0 $stable(sys_clk_low_ratio) |=> oversample_ratio ==
            ($past(sys_clk_low_ratio) ? {1'b0, $past(ctl_word[7], 2)}
                                      : ($past(ctl_word[7], 2) ? 2'h2 : 2'h1));
    endproperty
    a_osr: assert property (p_osr) else $error("oversampling ratio wrong"); // R08

    // read control lands in the store the edge after the word
    property p_wr_store;
        wr_rdidx |=> read_index_ctrl == $past(req_data);
    endproperty
    a_wr_store: assert property (p_wr_store) else $error("read control write lost"); // R07

    // gp bits and enable land in the store the edge after the word
    property p_wr_osgp;
        wr_osgp |=> oversample_gpout_ctrl == $past(req_data);
    endproperty
    a_wr_osgp: assert property (p_wr_osgp) else $error("gp control write lost"); // R11

    // a word for an index outside the bank leaves every stored bit alone
    property p_wr_drop;
        wr_req && !wr_deemph && !wr_rdidx && !wr_osgp |=> $stable(deemph_phase_flag_ctrl)
            && $stable(read_index_ctrl) && $stable(oversample_gpout_ctrl);
    endproperty
    a_wr_drop: assert property (p_wr_drop) else $error("foreign write stored"); // R07

    // auto read starts at the requested index and may be last at once
    property p_auto_first;
        rd_req && read_auto_inc |=> rd_word_valid && rd_word[14:8] == $past(req_idx)
            && rd_word_last == ($past(req_idx) >= $past(read_index));
    endproperty
    a_auto_first: assert property (p_auto_first) else $error("auto read start wrong"); // R06

    // an offered word stands untouched until the serial side takes it or a new read request comes
    property p_rd_hold;
        rd_word_valid && !rd_word_take && !rd_req |=> rd_word_valid && $stable(rd_word)
            && $stable(rd_word_last);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read word moved before take"); // R05

    // read words go out with the top bit clear
    property p_word_top;
        rd_word_valid |-> !rd_word[`DCRZF_RW_BIT];
    endproperty
    a_word_top: assert property (p_word_top) else $error("read word top bit set"); // R07
endmodule // dcrzf_top

// ### rtl/dcrzf_regs.svh
// register indices, field positions, reset values and counts of the control bank
// assumes: included by bare name from every design file that needs it
`ifndef DCRZF_REGS_SVH
`define DCRZF_REGS_SVH

// control word layout
`define DCRZF_RW_BIT 15
`define DCRZF_IDX_HI 14
`define DCRZF_IDX_LO 8
`define DCRZF_DATA_HI 7

// register indices
`define DCRZF_IDX_DEEMPH 7'h0a
`define DCRZF_IDX_RDIDX 7'h0b
`define DCRZF_IDX_OSGP 7'h0c

// deemph_phase_flag_ctrl fields
`define DCRZF_F_ZERO_POL 6
`define DCRZF_F_PHASE 5
`define DCRZF_F_RATE_HI 4
`define DCRZF_F_RATE_LO 3
`define DCRZF_F_DEEN_HI 2
`define DCRZF_F_DEEN_LO 0

// read_index_ctrl fields
`define DCRZF_F_INC 7
`define DCRZF_F_RDIDX_HI 6

// oversample_gpout_ctrl fields
`define DCRZF_F_OVER 7
`define DCRZF_F_GP_EN 6
`define DCRZF_F_GPO_HI 5

// reset values of the stored bits
`define DCRZF_RST_DEEMPH 7'h00
`define DCRZF_RST_RDIDX 8'h01
`define DCRZF_RST_OSGP 8'h00

// word-clock periods of zero data before a channel counts as silent
`define DCRZF_ZERO_RUN 11'h0400

`endif

// ### rtl/dcrzf_pkg.sv
// types shared by the control bank and its bench
// assumes: nothing beyond a SystemVerilog compiler
package dcrzf_pkg;
    // read sequencer states
    typedef enum logic [0:0] {dcrzf_rd_idle, dcrzf_rd_send} dcrzf_rd_state_t;
    // de-emphasis sample rate codes as stored
    typedef enum logic [1:0] {
        dcrzf_de_44k1 = 2'h0,
        dcrzf_de_48k = 2'h1,
        dcrzf_de_32k = 2'h2
    } dcrzf_de_rate_t;
    // resulting oversampling ratio
    typedef enum logic [1:0] {
        dcrzf_osr_32 = 2'h0,
        dcrzf_osr_64 = 2'h1,
        dcrzf_osr_128 = 2'h2
    } dcrzf_osr_t;
endpackage

// ### rtl/dcrzf_flag_if.sv
// carrier for the raw per-channel zero-detect flags
// assumes: one driver (detector) and one reader (pin mux)
`timescale 1ns/1ps
interface dcrzf_flag_if;
    logic [7:0] zero_det; // 1 while channel is in zero detect
    modport det (output zero_det);
    modport mux (input zero_det);
endinterface

// ### rtl/dcrzf_zero_det.sv
// per-channel zero-run counters on core_clk, stepped by the synchronised word clock
// assumes: chan_data_zero comes from logic on core_clk, word_clk_pin from a pin
`timescale 1ns/1ps
`include "dcrzf_regs.svh"
module dcrzf_zero_det (
    // clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // audio side
    input wire logic word_clk_pin,
    input wire logic [7:0] chan_data_zero,
    // flags out
    dcrzf_flag_if.det flags
);
    logic [2:0] wclk_sync; // three-stage pin synchroniser
    logic wclk_level; // accepted word clock level
    logic [10:0] run_cnt [8]; // zero-run count per channel
    wire wclk_agree = (wclk_sync[1] == wclk_sync[2]);
    wire wclk_rise = wclk_agree && wclk_sync[1] && !wclk_level;

    // synchroniser; stage 0 feeds stage 1 only
    always_ff @(posedge core_clk) begin
        if (srst) begin
            wclk_sync <= 3'h0;
            wclk_level <= 1'b0;
        end else begin
            wclk_sync <= {wclk_sync[1:0], word_clk_pin};
            if (wclk_agree) begin
                wclk_level <= wclk_sync[1];
            end
        end
    end

    // counters; nonzero data clears at once, no wait for a period
    always_ff @(posedge core_clk) begin
        for (int ch = 0; ch < 8; ch++) begin
            if (srst || !chan_data_zero[ch]) begin
                run_cnt[ch] <= 11'h000; // R17
            end else if (wclk_rise && run_cnt[ch] != `DCRZF_ZERO_RUN) begin
                run_cnt[ch] <= 11'(run_cnt[ch] + 11'h001); // R12
            end
        end
    end

    // saturated count means zero detect
    for (genvar g = 0; g < 8; g++) begin : g_flag
        assign flags.zero_det[g] = (run_cnt[g] == `DCRZF_ZERO_RUN); // R12
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    property p_run_clear;
        !chan_data_zero[0] |=> run_cnt[0] == 11'h000 && !flags.zero_det[0];
    endproperty
    a_run_clear: assert property (p_run_clear) else $error("zero run not cleared"); // R17

    property p_run_reach;
        chan_data_zero[3] && wclk_rise && run_cnt[3] == 11'h03ff |=> flags.zero_det[3];
    endproperty
    a_run_reach: assert property (p_run_reach) else $error("zero detect late"); // R12

    property p_run_early;
        !flags.zero_det[5] ##1 flags.zero_det[5] |-> $past(wclk_rise);
    endproperty
    a_run_early: assert property (p_run_early) else $error("zero detect without period"); // R12
endmodule // dcrzf_zero_det

// ### rtl/dcrzf_pin_mux.sv
// polarity and general-purpose sharing of the zero-flag pins, registered
// assumes: control bits come from the bank on the same clock
`timescale 1ns/1ps
module dcrzf_pin_mux (
    // clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // flags and controls
    dcrzf_flag_if.mux flags,
    input wire logic zero_flag_polarity,
    input wire logic gp_out_enable,
    input wire logic [5:0] gp_out_bit,
    // pins
    output logic [5:0] shared_pin,
    output logic [1:0] chan_zero_flag,
    output logic all_zero_flag
);
    wire [7:0] pol_flag = flags.zero_det ^ {8{zero_flag_polarity}}; // R15 R16
    wire all_det = &flags.zero_det; // R14
    wire [5:0] next_shared = gp_out_enable ? gp_out_bit : pol_flag[5:0]; // R10 R11

    // pins come from flops; reset shows inactive flags, polarity 0
    always_ff @(posedge core_clk) begin
        if (srst) begin
            shared_pin <= 6'h00;
            chan_zero_flag <= 2'h0;
            all_zero_flag <= 1'b0;
        end else begin
            shared_pin <= next_shared; // R10
            chan_zero_flag <= pol_flag[7:6]; // R13
            all_zero_flag <= all_det ^ zero_flag_polarity; // R14 R15
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    property p_gpo;
        gp_out_enable |=> shared_pin == $past(gp_out_bit);
    endproperty
    a_gpo: assert property (p_gpo) else $error("gp output not on pin"); // R11

    property p_flag_pol;
        !gp_out_enable |=> shared_pin[2] == ($past(flags.zero_det[2]) ^ $past(zero_flag_polarity));
    endproperty
    a_flag_pol: assert property (p_flag_pol) else $error("zero flag polarity wrong"); // R16

    property p_all;
        1'b1 |=> all_zero_flag == ((&$past(flags.zero_det)) ^ $past(zero_flag_polarity));
    endproperty
    a_all: assert property (p_all) else $error("combined flag wrong"); // R14
endmodule // dcrzf_pin_mux

// ### verification/dcrzf_host_model.sv
// host model on the serial control side: sends control words, takes read words
// assumes: the bank takes a word on a one-cycle valid pulse, all on core_clk
`timescale 1ns/1ps
module dcrzf_host_model (
    // clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // control words out
    output logic ctl_word_valid,
    output logic [15:0] ctl_word,
    // read words in
    output logic rd_word_take,
    input wire logic rd_word_valid,
    input wire logic [15:0] rd_word,
    input wire logic rd_word_last
);
    int take_gap; // idle cycles before each take, 0 answers promptly

    // idle bus at time zero
    initial begin
        ctl_word_valid = 1'b0;
        ctl_word = 16'h0000;
        rd_word_take = 1'b0;
        take_gap = 0;
    end

    // one word for one cycle, then the word lines no longer hold it
    task automatic send(input logic [15:0] wd);
        @(posedge core_clk);
        #1;
        ctl_word_valid = 1'b1;
        ctl_word = wd;
        @(posedge core_clk);
        #1;
        ctl_word_valid = 1'b0;
        ctl_word = ~wd; // stale word must not be used
    endtask

    // register write: top bit low
    task automatic write_reg(input logic [6:0] idx, input logic [7:0] data);
        send({1'b0, idx, data});
    endtask

    // read request, then take n words; a missing word comes back unknown
    task automatic read_seq(input logic [6:0] idx, input logic [7:0] junk, input int n,
                            output logic [15:0] w [0:3], output logic [3:0] last);
        int k;
        int tries;
        send({1'b1, idx, junk});
        for (k = 0; k < n; k++) begin
            tries = 0;
            while (rd_word_valid !== 1'b1 && tries < 16) begin
                @(posedge core_clk);
                #1;
                tries++;
            end
            // slow host leaves the word standing a while
            repeat (take_gap) begin
                @(posedge core_clk);
                #1;
            end
            w[k] = (rd_word_valid === 1'b1) ? rd_word : 16'hxxxx;
            last[k] = rd_word_last;
            rd_word_take = 1'b1;
            @(posedge core_clk);
            #1;
            rd_word_take = 1'b0;
        end
    endtask
endmodule // dcrzf_host_model

// ### verification/tb.sv
// self-checking bench for the control bank and zero-flag pins
// assumes: dcrzf_top as delivered, host model drives the control side
`timescale 1ns/1ps
module tb;
    // design signals
    logic core_clk, srst, ctl_word_valid, rd_word_take, rd_word_valid, rd_word_last;
    logic [15:0] ctl_word, rd_word;
    logic sys_clk_low_ratio, word_clk_pin, output_phase_invert, deemph_enable, all_zero_flag;
    logic [7:0] chan_data_zero;
    logic [5:0] shared_pin;
    logic [1:0] chan_zero_flag;
    dcrzf_pkg::dcrzf_de_rate_t deemph_rate_sel;
    dcrzf_pkg::dcrzf_osr_t oversample_ratio;
    // bench state
    int fails = 0;
    int check_count = 0;
    int cycles = 0;
    logic [15:0] w [0:3];
    logic [3:0] l;
    // one row: 0x0a byte, 0x0c byte, strap, {phase, enable, rate, ratio}
    typedef struct packed {
        logic [7:0] de;
        logic [7:0] os;
        logic strap;
        logic [5:0] exp;
    } dcrzf_row_t;
    dcrzf_row_t rows [0:9] = '{
        '{8'h00, 8'h00, 1'b0, 6'h01}, '{8'h01, 8'h80, 1'b0, 6'h12},
        '{8'h02, 8'h00, 1'b1, 6'h10}, '{8'h04, 8'h80, 1'b1, 6'h11},
        '{8'h08, 8'h00, 1'b0, 6'h05}, '{8'h10, 8'h00, 1'b0, 6'h09},
        '{8'h18, 8'h00, 1'b0, 6'h01}, '{8'h20, 8'h00, 1'b0, 6'h21},
        '{8'he7, 8'h00, 1'b0, 6'h31}, '{8'h00, 8'h00, 1'b0, 6'h01}};

    dcrzf_top i_dut (.core_clk(core_clk), .srst(srst), .ctl_word_valid(ctl_word_valid),
        .ctl_word(ctl_word), .rd_word_take(rd_word_take), .rd_word_valid(rd_word_valid),
        .rd_word(rd_word), .rd_word_last(rd_word_last), .sys_clk_low_ratio(sys_clk_low_ratio),
        .word_clk_pin(word_clk_pin), .chan_data_zero(chan_data_zero),
        .output_phase_invert(output_phase_invert), .deemph_enable(deemph_enable),
        .deemph_rate_sel(deemph_rate_sel), .oversample_ratio(oversample_ratio),
        .shared_pin(shared_pin), .chan_zero_flag(chan_zero_flag),
        .all_zero_flag(all_zero_flag));
    dcrzf_host_model i_host (.core_clk(core_clk), .srst(srst),
        .ctl_word_valid(ctl_word_valid), .ctl_word(ctl_word), .rd_word_take(rd_word_take),
        .rd_word_valid(rd_word_valid), .rd_word(rd_word), .rd_word_last(rd_word_last));

    // 50 MHz core clock
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    // word clock, ten core cycles a period
    initial begin
        word_clk_pin = 1'b0;
        forever begin
            repeat (5) @(posedge core_clk);
            #1;
            word_clk_pin = ~word_clk_pin;
        end
    end
    // hang guard, far above the roughly 10.5k cycles needed
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 30000) begin
            fails++;
            conclude();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wait_cycles(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        int i;
        srst = 1'b1;
        sys_clk_low_ratio = 1'b0;
        chan_data_zero = 8'h00; // nonzero data keeps run counters clear
        repeat (20) @(posedge core_clk);
        #1;
        srst = 1'b0;
        wait_cycles(2);
        check({7'h00, shared_pin, chan_zero_flag, all_zero_flag}, 16'h0000);
        check({10'h000, output_phase_invert, deemph_enable, deemph_rate_sel,
               oversample_ratio}, 16'h0001);
        i_host.read_seq(7'h0c, 8'h00, 1, w, l);
        check(w[0], 16'h0100);
        check({15'h0000, l[0]}, 16'h0001);
        // dropped write, then auto-increment read with a slow host
        i_host.write_reg(7'h05, 8'hff);
        i_host.write_reg(7'h0b, 8'h8c);
        i_host.take_gap = 2;
        i_host.read_seq(7'h0a, 8'hff, 3, w, l);
        check(w[0], 16'h0a00);
        check(w[1], 16'h0b8c);
        check(w[2], 16'h0c00);
        check({13'h0000, l[2:0]}, 16'h0004);
        check({15'h0000, rd_word_valid}, 16'h0000);
        // start already at the last index gives one word
        i_host.take_gap = 0;
        i_host.read_seq(7'h0c, 8'h00, 1, w, l);
        check({w[0][15:1], l[0]}, 16'h0c01);
        i_host.write_reg(7'h0b, 8'h0a);
        // control rows, each read back through a single read
        for (i = 0; i < 10; i++) begin
            i_host.write_reg(7'h0a, rows[i].de);
            i_host.write_reg(7'h0c, rows[i].os);
            sys_clk_low_ratio = rows[i].strap;
            wait_cycles(3);
            check({10'h000, output_phase_invert, deemph_enable, deemph_rate_sel,
                   oversample_ratio}, {10'h000, rows[i].exp});
            i_host.read_seq(7'h0b, 8'h00, 1, w, l);
            check(w[0], {8'h0a, rows[i].de & 8'h7f});
        end
        // zero detect: 1023 periods is not enough, 1024 is
        @(negedge word_clk_pin);
        wait_cycles(1);
        chan_data_zero = 8'hff;
        repeat (1023) @(posedge word_clk_pin);
        wait_cycles(8);
        check({7'h00, shared_pin, chan_zero_flag, all_zero_flag}, 16'h0000);
        @(posedge word_clk_pin);
        wait_cycles(8);
        check({7'h00, shared_pin, chan_zero_flag, all_zero_flag}, 16'h01ff);
        chan_data_zero = 8'hfe;
        wait_cycles(3);
        check({7'h00, shared_pin, chan_zero_flag, all_zero_flag}, 16'h01f6);
        i_host.write_reg(7'h0a, 8'h40);
        wait_cycles(3);
        check({7'h00, shared_pin, chan_zero_flag, all_zero_flag}, 16'h0009);
        i_host.write_reg(7'h0c, 8'h6a);
        wait_cycles(3);
        check({7'h00, shared_pin, chan_zero_flag, all_zero_flag}, 16'h0151);
        i_host.write_reg(7'h0c, 8'h55);
        wait_cycles(3);
        check({7'h00, shared_pin, chan_zero_flag, all_zero_flag}, 16'h00a9);
        i_host.write_reg(7'h0c, 8'h00);
        wait_cycles(3);
        check({7'h00, shared_pin, chan_zero_flag, all_zero_flag}, 16'h0009);
        // mid-run reset restores defaults; zero-run counters restart from zero
        srst = 1'b1;
        wait_cycles(2);
        srst = 1'b0;
        wait_cycles(2);
        check({7'h00, shared_pin, chan_zero_flag, all_zero_flag}, 16'h0000);
        check({10'h000, output_phase_invert, deemph_enable, deemph_rate_sel,
               oversample_ratio}, 16'h0001);
        i_host.read_seq(7'h0c, 8'h00, 1, w, l);
        check({w[0][15:1], l[0]}, 16'h0101);
        conclude();
    end
endmodule // tb
